// ### common/ppg_pkg.sv
// Package with constants and carrier types for the port parity block.
package ppg_pkg;
    // Port word width and byte layout.
    localparam int WORD_W = 36;
    localparam int BYTE_W = 9;
    localparam int BYTES = 4;
    // Position of the parity bit inside a byte.
    localparam int PAR_POS = 8;
    // Reset value of the buffered output word.
    localparam logic [35:0] WORD_RST = 36'h0_0000_0000;
    // Reset value of a port's synced strobes: deselected, nothing asked.
    localparam logic [4:0] CTL_RST = 5'h10;
    // Buffer depth of the port-B output path.
    localparam int BUF_DEPTH = 2;

    // One port's control strobes, all sampled on the port clock.
    typedef struct packed {
        logic select_n;
        logic enable;
        logic write_not_read;
        logic mailbox_select;
        logic parity_generate;
    } ppg_ctl_type;
endpackage

// ### hdl/ppg_buf2.sv
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/1ps
`default_nettype none
module ppg_buf2 (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Filling side.
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [35:0] in_data_i,
    // Draining side.
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [35:0] out_data_o
);
    // Storage entries and fill count; head is always entry zero.
    logic [35:0] mem_q [ppg_pkg::BUF_DEPTH];
    logic [1:0] cnt_q;
    logic push;
    logic pop;

    assign in_ready_o = (cnt_q != 2'h2);
    assign out_valid_o = (cnt_q != 2'h0);
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    // Fill count tracks pushes and pops.
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cnt_q <= 2'h0;
        end else begin
            cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
        end
    end

    // Data shift: a pop moves entry one forward, a push lands behind it.
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            mem_q[0] <= ppg_pkg::WORD_RST;
            mem_q[1] <= ppg_pkg::WORD_RST;
        end else begin
            if (pop) begin
                mem_q[0] <= mem_q[1];
            end
            if (push) begin
                if (cnt_q == 2'h0 || (cnt_q == 2'h1 && pop)) begin
                    mem_q[0] <= in_data_i;
                end else begin
                    mem_q[1] <= in_data_i;
                end
            end
        end
    end

    // Head word comes straight from a register.
    assign out_data_o = mem_q[0];
endmodule
`default_nettype wire

// ### hdl/ppg_port_parity.sv
// Port parity checking and generation for both ports of the FIFO.
// Contract
// RULE1: Port-A mailbox generate read forces error high.
// RULE2: Port-B mailbox generate read forces error high.
// RULE3: Generate parity on reads when generate select high.
// RULE4: Four nine-bit bytes, top bit is parity.
// RULE5: Writes store all 36 bits unchanged.
// RULE6: Parity from lower eight bits, odd/even select.
// RULE7: Generated bits replace stored top bits outgoing.
// RULE8: FIFO parity applied before output register.
// RULE9: Controller holds selects stable at load edge.
// RULE10: Mailbox generation only on enabled mailbox read; code needs no read, only parity_generate (and mailbox_select on port B).
// RULE11: Mailbox contents never altered by generation.
// RULE12: Error flag low when any byte fails.
// RULE13: Port-B outputs: FIFO register or a-to-b mailbox.
// RULE14: Port-A outputs always show b-to-a mailbox.
// RULE15: Odd mode: odd ones across nine bits.
`timescale 1ns/1ps
`default_nettype none
module ppg_port_parity (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Parity sense, high for odd.
    input wire logic odd_even_i,
    // Port-A control and bus.
    input wire ppg_pkg::ppg_ctl_type port_a_ctl_i,
    input wire logic [35:0] port_a_bus_i,
    output logic [35:0] port_a_bus_o,
    output logic port_a_bus_oe_n_o,
    output logic port_a_parity_error_n_o,
    // Port-B control and bus.
    input wire ppg_pkg::ppg_ctl_type port_b_ctl_i,
    input wire logic [35:0] port_b_bus_i,
    output logic [35:0] port_b_bus_o,
    output logic port_b_bus_oe_n_o,
    output logic port_b_parity_error_n_o,
    // Stored mailbox words.
    input wire logic [35:0] a_to_b_mailbox_i,
    input wire logic [35:0] b_to_a_mailbox_i,
    // FIFO RAM read word and handshake.
    input wire logic fifo_valid_i,
    output logic fifo_ready_o,
    input wire logic [35:0] fifo_data_i
);
    // Generated parity bit of one byte from its lower eight bits.
    function automatic logic gen_bit(input logic [7:0] low, input logic odd);
        gen_bit = (^low) ^ odd; // see RULE6 see RULE15
    endfunction

    // Replace the top bit of every byte with generated parity.
    function automatic logic [35:0] gen_word(input logic [35:0] w,
                                             input logic odd);
        logic [35:0] r;
        r = w;
        for (int i = 0; i < ppg_pkg::BYTES; i++) begin
            r[i*ppg_pkg::BYTE_W + ppg_pkg::PAR_POS] =
                gen_bit(w[i*ppg_pkg::BYTE_W +: 8], odd); // see RULE4
        end
        gen_word = r;
    endfunction

    // True when any byte has the wrong count of low bits.
    function automatic logic any_fail(input logic [35:0] w, input logic odd);
        logic f;
        f = 1'b0;
        for (int i = 0; i < ppg_pkg::BYTES; i++) begin
            // Odd low count in odd mode, even low count in even mode fails.
            f = f | ((^(~w[i*ppg_pkg::BYTE_W +: ppg_pkg::BYTE_W])) == odd);
        end
        any_fail = f;
    endfunction

    // Synchronised pins: two flip-flops before any logic.
    ppg_pkg::ppg_ctl_type a_ctl_m, a_ctl_s, b_ctl_m, b_ctl_s;
    logic [35:0] a_bus_m, a_bus_s, b_bus_m, b_bus_s;
    logic odd_m, odd_s;

    // Double-flop every pin input; first stage read only by second.
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            a_ctl_m <= ppg_pkg::CTL_RST;
            a_ctl_s <= ppg_pkg::CTL_RST;
            b_ctl_m <= ppg_pkg::CTL_RST;
            b_ctl_s <= ppg_pkg::CTL_RST;
            a_bus_m <= ppg_pkg::WORD_RST;
            a_bus_s <= ppg_pkg::WORD_RST;
            b_bus_m <= ppg_pkg::WORD_RST;
            b_bus_s <= ppg_pkg::WORD_RST;
            odd_m <= 1'b0;
            odd_s <= 1'b0;
        end else begin
            a_ctl_m <= port_a_ctl_i;
            a_ctl_s <= a_ctl_m;
            b_ctl_m <= port_b_ctl_i;
            b_ctl_s <= b_ctl_m;
            a_bus_m <= port_a_bus_i;
            a_bus_s <= a_bus_m;
            b_bus_m <= port_b_bus_i;
            b_bus_s <= b_bus_m;
            odd_m <= odd_even_i;
            odd_s <= odd_m;
        end
    end

    // Read and mailbox generate decode per port.
    logic a_read, b_read, a_mb_gen, b_mb_gen;
    assign a_read = !a_ctl_s.select_n && a_ctl_s.enable &&
                    !a_ctl_s.write_not_read;
    assign b_read = !b_ctl_s.select_n && b_ctl_s.enable &&
                    !b_ctl_s.write_not_read;
    assign a_mb_gen = a_read && a_ctl_s.mailbox_select &&
                      a_ctl_s.parity_generate; // see RULE10
    assign b_mb_gen = b_read && b_ctl_s.mailbox_select &&
                      b_ctl_s.parity_generate; // see RULE10

    // Parity error flags; the a_mb_gen and b_mb_gen decodes force them high on a mailbox generate read.
    // The mailbox inputs are only read here, never written, so contents
    // stay intact and writes elsewhere keep all 36 bits.
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            port_a_parity_error_n_o <= 1'b1;
            port_b_parity_error_n_o <= 1'b1;
        end else begin
            port_a_parity_error_n_o <= a_mb_gen ? 1'b1 : // see RULE1
                !any_fail(a_bus_s, odd_s); // see RULE12
            port_b_parity_error_n_o <= b_mb_gen ? 1'b1 : // see RULE2
                !any_fail(b_bus_s, odd_s); // see RULE12
        end
    end

    // FIFO path: parity applied ahead of the output buffer register.
    logic [35:0] fifo_word;
    logic [35:0] fifo_out;
    logic fifo_out_valid;
    logic fifo_take;
    // The select sampled at this edge must be stable, as the controller
    // is required to hold it around the load edge.
    assign fifo_word = b_ctl_s.parity_generate ?
        gen_word(fifo_data_i, odd_s) : fifo_data_i; // see RULE8 see RULE9
    assign fifo_take = b_read && !b_ctl_s.mailbox_select;

    ppg_buf2 u_buf (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .in_valid_i(fifo_valid_i),
        .in_ready_o(fifo_ready_o),
        .in_data_i(fifo_word),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(fifo_take),
        .out_data_o(fifo_out)
    );

    // Output words; mailbox data altered only on the outgoing copy.
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            port_a_bus_o <= ppg_pkg::WORD_RST;
            port_b_bus_o <= ppg_pkg::WORD_RST;
        end else begin
            port_a_bus_o <= a_ctl_s.parity_generate ? // see RULE14
                gen_word(b_to_a_mailbox_i, odd_s) : // see RULE3 see RULE7
                b_to_a_mailbox_i; // see RULE11 see RULE5
            if (b_ctl_s.mailbox_select) begin
                port_b_bus_o <= b_ctl_s.parity_generate ? // see RULE13
                    gen_word(a_to_b_mailbox_i, odd_s) : // see RULE3
                    a_to_b_mailbox_i; // see RULE11
            end else if (fifo_take && fifo_out_valid) begin
                port_b_bus_o <= fifo_out; // see RULE13
            end
        end
    end

    // Bus drive enables, active low, while the port reads.
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            port_a_bus_oe_n_o <= 1'b1;
            port_b_bus_oe_n_o <= 1'b1;
        end else begin
            port_a_bus_oe_n_o <= !a_read;
            port_b_bus_oe_n_o <= !b_read;
        end
    end

    // Checks.
    sequence s_a_gen;
        a_mb_gen;
    endsequence
    chk_a_flag_held: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        s_a_gen |=> port_a_parity_error_n_o) // see RULE1
        else $error("port A error flag not held high");
    chk_b_flag_held: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        b_mb_gen |=> port_b_parity_error_n_o) // see RULE2
        else $error("port B error flag not held high");
    chk_a_err_low: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (!a_mb_gen && any_fail(a_bus_s, odd_s)) |=>
        !port_a_parity_error_n_o) // see RULE12
        else $error("port A error missed");
    chk_b_err_low: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (!b_mb_gen && any_fail(b_bus_s, odd_s)) |=>
        !port_b_parity_error_n_o) // see RULE12
        else $error("port B error missed");
    chk_a_mail_out: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !a_ctl_s.parity_generate |=>
        port_a_bus_o == $past(b_to_a_mailbox_i)) // see RULE14
        else $error("port A output not mailbox");
    chk_a_gen_par: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        a_ctl_s.parity_generate |=>
        !any_fail(port_a_bus_o, $past(odd_s))) // see RULE7
        else $error("port A generated parity wrong");
    chk_b_mail_out: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        b_ctl_s.mailbox_select && b_ctl_s.parity_generate |=>
        port_b_bus_o[7:0] == $past(a_to_b_mailbox_i[7:0]) &&
        !any_fail(port_b_bus_o, $past(odd_s))) // see RULE13
        else $error("port B mailbox output wrong");
    chk_fifo_gen: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        fifo_valid_i && fifo_ready_o && b_ctl_s.parity_generate |->
        !any_fail(fifo_word, odd_s)) // see RULE8
        else $error("FIFO word parity not generated");
endmodule
`default_nettype wire

// ### sim/ppg_fifo_src.sv
// Partner model of the FIFO RAM read side that feeds the parity block.
`timescale 1ns/1ps
`default_nettype none
module ppg_fifo_src (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Bench request for one word.
    input wire logic req_i,
    input wire logic [35:0] word_i,
    // Handshake toward the block.
    input wire logic ready_i,
    output logic valid_o,
    output logic [35:0] data_o
);
    // The word is held until ready is seen high at an edge.
    // Once it is released the bus shows the inverse, so stale data never
    // passes for a fresh word.
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            valid_o <= 1'b0;
            data_o <= 36'hf_ffff_ffff;
        end else if (valid_o && ready_i) begin
            valid_o <= 1'b0;
            data_o <= ~data_o;
        end else if (req_i && !valid_o) begin
            valid_o <= 1'b1;
            data_o <= word_i;
        end
    end
endmodule
`default_nettype wire

// ### sim/ppg_port_parity_tb_top.sv
// Self-checking testbench for the port parity block.
`timescale 1ns/1ps
`default_nettype none
module ppg_port_parity_tb_top;
    logic clk_i, sys_rst_i, odd_even_i, f_req;
    ppg_pkg::ppg_ctl_type ca, cb;
    logic [35:0] a_in, b_in, a_out, b_out, a2b, b2a, f_data, f_word;
    logic a_oe_n, b_oe_n, a_err_n, b_err_n, f_valid, f_ready;
    logic [35:0] w[3];
    logic exp_a, exp_b;
    logic [35:0] exp_w;
    int n_mismatch, samples_checked, seed, cyc;

    ppg_port_parity u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .odd_even_i(odd_even_i), .port_a_ctl_i(ca), .port_a_bus_i(a_in),
        .port_a_bus_o(a_out), .port_a_bus_oe_n_o(a_oe_n),
        .port_a_parity_error_n_o(a_err_n), .port_b_ctl_i(cb),
        .port_b_bus_i(b_in), .port_b_bus_o(b_out),
        .port_b_bus_oe_n_o(b_oe_n), .port_b_parity_error_n_o(b_err_n),
        .a_to_b_mailbox_i(a2b), .b_to_a_mailbox_i(b2a),
        .fifo_valid_i(f_valid), .fifo_ready_o(f_ready), .fifo_data_i(f_data));
    ppg_fifo_src u_src (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .req_i(f_req),
        .word_i(f_word), .ready_i(f_ready), .valid_o(f_valid),
        .data_o(f_data));

    // Clock of 40 ns period.
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    // When pg is high, replace each byte's top bit by the parity of its lower eight bits.
    function automatic logic [35:0] gen_f(input logic [35:0] v,
                                          input logic pg, input logic odd);
        logic [35:0] r;
        r = v;
        for (int i = 0; i < 4; i++) begin
            if (pg) r[9*i+8] = odd ^ (^v[9*i+:8]);
        end
        return r;
    endfunction

    // High when every nine-bit byte meets the selected sense.
    function automatic logic ok_f(input logic [35:0] v, input logic odd);
        logic r;
        r = 1'b1;
        for (int i = 0; i < 4; i++) begin
            if ((^v[9*i+:9]) != odd) r = 1'b0;
        end
        return r;
    endfunction

    function automatic logic rd_f(input ppg_pkg::ppg_ctl_type c);
        return !c.select_n && c.enable && !c.write_not_read;
    endfunction

    function automatic logic [35:0] rnd_f();
        logic [63:0] t;
        t = {$random(seed), $random(seed)};
        return t[35:0];
    endfunction

    task automatic chk_w(input string n, input logic [35:0] e, g);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic chk_b(input string n, input logic e, g);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %b seen %b", n, e, g);
        end
    endtask

    // Pins pass two sync flops and an output register, so wait past that.
    task automatic settle(input int n);
        repeat (n) @(posedge clk_i);
        @(negedge clk_i);
    endtask

    // The request is held one edge; the model then holds the word itself.
    task automatic push(input logic [35:0] v, input logic wait_done);
        f_word <= v;
        f_req <= 1'b1;
        @(posedge clk_i);
        f_req <= 1'b0;
        for (int k = 0; k < 20 && wait_done; k++) begin
            @(posedge clk_i);
            if (!f_valid) break;
        end
    endtask

    task automatic end_sim();
        $display("compares %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // A hang counts as a mismatch and goes to the closing report.
    always @(posedge clk_i) begin
        cyc++;
        if (cyc > 5000) begin
            n_mismatch++;
            end_sim();
        end
    end

    initial begin
        seed = 64;
        {sys_rst_i, odd_even_i, f_req, ca, cb} = {3'b100, 10'h210};
        {a_in, b_in, a2b, b2a, f_word} = '0;
        repeat (10) @(posedge clk_i);
        @(negedge clk_i);
        chk_b("rst a_oe_n", 1'b1, a_oe_n);
        chk_b("rst b_err_n", 1'b1, b_err_n);
        @(posedge clk_i);
        sys_rst_i <= 1'b0;
        // Random traffic with forced mailbox reads among it.
        for (int i = 0; i < 48; i++) begin
            @(posedge clk_i);
            odd_even_i <= 1'($random(seed));
            ca <= (i % 3 == 1) ? 5'h0b : 5'($random(seed));
            cb <= (i % 3 == 1) ? 5'h0b :
                  (i % 3 == 2) ? 5'h0a : 5'($random(seed));
            a_in <= (i == 0) ? 36'h0_0000_0000 : rnd_f();
            b_in <= rnd_f();
            a2b <= rnd_f();
            b2a <= (i == 0) ? 36'hf_ffff_ffff : rnd_f();
            settle(6);
            exp_a = (rd_f(ca) && ca.mailbox_select && ca.parity_generate) ||
                    ok_f(a_in, odd_even_i);
            exp_b = (rd_f(cb) && cb.mailbox_select && cb.parity_generate) ||
                    ok_f(b_in, odd_even_i);
            chk_b("a_err_n", exp_a, a_err_n);
            chk_b("b_err_n", exp_b, b_err_n);
            exp_w = gen_f(b2a, ca.parity_generate, odd_even_i);
            chk_w("a_out", exp_w, a_out);
            chk_b("a_oe_n", !rd_f(ca), a_oe_n);
            chk_b("b_oe_n", !rd_f(cb), b_oe_n);
            exp_w = gen_f(a2b, cb.parity_generate, odd_even_i);
            if (rd_f(cb) && cb.mailbox_select) begin
                chk_w("b_out", exp_w, b_out);
            end
        end
        $display("test random mailbox done");
        // Fill the buffer with port B idle, then drain it by FIFO reads.
        w = '{36'hf_ffff_ffff, rnd_f(), rnd_f()};
        @(posedge clk_i);
        cb <= 5'h11;
        odd_even_i <= 1'b1;
        // Let the new selects pass the sync flops before the first push.
        repeat (3) @(posedge clk_i);
        push(w[0], 1'b1);
        push(w[1], 1'b1);
        push(w[2], 1'b0);
        settle(10);
        chk_b("refused ready", 1'b0, f_ready);
        chk_b("refused valid", 1'b1, f_valid);
        // One-edge read pulses pop one word each; the last read is held.
        for (int k = 0; k < 3; k++) begin
            @(posedge clk_i);
            cb <= 5'h09;
            @(posedge clk_i);
            cb <= (k == 2) ? 5'h09 : 5'h11;
            settle(4);
            exp_w = gen_f(w[k], 1'b1, 1'b1);
            chk_w("fifo b_out", exp_w, b_out);
        end
        chk_b("drained ready", 1'b1, f_ready);
        chk_b("b_oe_n", 1'b0, b_oe_n);
        $display("test fifo fill drain done");
        end_sim();
    end
endmodule
`default_nettype wire
